// ### hw/cadr_map.svh
// constants of the configuration address decode router: ports, field positions, resets
// assumes inclusion by bare name from every file that needs a number of this block
`ifndef CADR_MAP_SVH
`define CADR_MAP_SVH

// ********************************************************************
// processor i/o ports
// ********************************************************************
`define CADR_ADDR_PORT   16'h0CF8
`define CADR_DATA_PORT   16'h0CFC
`define CADR_BE_FULL     4'hF

// ********************************************************************
// address port fields
// ********************************************************************
`define CADR_EN_BIT      31
`define CADR_BUS_HI      23
`define CADR_BUS_LO      16
`define CADR_DEV_HI      15
`define CADR_DEV_LO      11
`define CADR_FN_HI       10
`define CADR_FN_LO       8
`define CADR_REG_HI      7
`define CADR_REG_LO      2
`define CADR_ADDR_WMASK  32'h80FF_FFFC
`define CADR_ADDR_RST    32'h0000_0000
`define CADR_DATA_RST    32'h0000_0000

// ********************************************************************
// bus 0 device numbers and limits
// ********************************************************************
`define CADR_BUS_ZERO    8'h00
`define CADR_DEV_HOST    5'h00
`define CADR_DEV_PEXB    5'h01
`define CADR_DEV_GFX     5'h02
`define CADR_FN_MAX      3'h1
`define CADR_ABORT_DATA  32'hFFFF_FFFF

`endif

// ### hw/cadr_pkg.sv
// types of the configuration address decode router
// assumes nothing beyond a SystemVerilog compiler
`default_nettype none

package cadr_pkg;
	// control states, one-hot
	typedef enum logic [2:0] {
		ST_IDLE = 3'h1,
		ST_WAIT = 3'h2,
		ST_DONE = 3'h4
	} cadr_state_e;

	// decoded destination of a configuration access
	typedef enum logic [5:0] {
		RT_INT   = 6'h01,
		RT_PEX0  = 6'h02,
		RT_PEX1  = 6'h04,
		RT_HUB0  = 6'h08,
		RT_HUB1  = 6'h10,
		RT_ABORT = 6'h20
	} cadr_route_e;

	// which answer the control waits for
	typedef enum logic [2:0] {
		TG_INT = 3'h1,
		TG_PEX = 3'h2,
		TG_HUB = 3'h4
	} cadr_target_e;
endpackage

`default_nettype wire

// ### hw/cadr_route_if.sv
// carrier between the router top and its address decoder
// assumes both ends are built in the same clock domain; contents are combinational
`timescale 1ns/100ps
`default_nettype none

interface cadr_route_if;
	logic [31:0]             addr;
	logic [7:0]              sec_bus;
	logic [7:0]              sub_bus;
	logic                    gfx_present;
	cadr_pkg::cadr_route_e   route;
	logic [7:0]              bus;
	logic [4:0]              dev;
	logic [2:0]              func;
	logic [5:0]              regno;
	logic [31:0]             hub_addr;
	logic [7:0]              pex_b6;
	logic [7:0]              pex_b7;
	logic [7:0]              pex_b8;

	modport dec (
		input  addr, sec_bus, sub_bus, gfx_present,
		output route, bus, dev, func, regno, hub_addr, pex_b6, pex_b7, pex_b8
	);
	modport top (
		output addr, sec_bus, sub_bus, gfx_present,
		input  route, bus, dev, func, regno, hub_addr, pex_b6, pex_b7, pex_b8
	);
endinterface

`default_nettype wire

// ### hw/cadr_decode.sv
// decoder of the configuration address port into a destination and its header fields
// assumes the address port value and bridge bus numbers are stable while read
`timescale 1ns/100ps
`default_nettype none
`include "cadr_map.svh"

module cadr_decode (
	cadr_route_if.dec rif
);
	logic hub_type1;

	// ********************************************************************
	// field split and header placement
	// ********************************************************************
	assign rif.bus   = rif.addr[`CADR_BUS_HI:`CADR_BUS_LO];
	assign rif.dev   = rif.addr[`CADR_DEV_HI:`CADR_DEV_LO];
	assign rif.func  = rif.addr[`CADR_FN_HI:`CADR_FN_LO];
	assign rif.regno = rif.addr[`CADR_REG_HI:`CADR_REG_LO]; // RL10
	assign hub_type1 = (rif.route == cadr_pkg::RT_HUB1);
	// bus field only rides on the hub address for type 1
	assign rif.hub_addr = {8'h00, hub_type1 ? rif.bus : `CADR_BUS_ZERO,
		rif.dev, rif.func, rif.regno, 2'h0}; // RL5 RL7 RL9 RL10
	assign rif.pex_b8 = rif.bus; // RL5
	assign rif.pex_b6 = {rif.dev, rif.func}; // RL7 RL9
	assign rif.pex_b7 = {rif.regno, 2'h0}; // RL10

	// ********************************************************************
	// destination choice
	// ********************************************************************
	// internal devices answer only functions 0 and 1; the graphics slot
	// falls through to the hub when that function is absent
	always_comb begin
		rif.route = cadr_pkg::RT_HUB1;
		if (rif.bus == `CADR_BUS_ZERO) begin
			if (rif.dev == `CADR_DEV_HOST || rif.dev == `CADR_DEV_PEXB ||
				(rif.dev == `CADR_DEV_GFX && rif.gfx_present)) begin // RL6
				if (rif.func > `CADR_FN_MAX)
					rif.route = cadr_pkg::RT_ABORT; // RL8
				else
					rif.route = cadr_pkg::RT_INT; // RL6
			end else begin
				rif.route = cadr_pkg::RT_HUB0; // RL1
			end
		end else if (rif.bus == rif.sec_bus) begin
			if (rif.dev != `CADR_DEV_HOST)
				rif.route = cadr_pkg::RT_ABORT; // RL15
			else
				rif.route = cadr_pkg::RT_PEX0; // RL3
		end else if (rif.bus > rif.sec_bus && rif.bus <= rif.sub_bus) begin
			rif.route = cadr_pkg::RT_PEX1; // RL4
		end else begin
			rif.route = cadr_pkg::RT_HUB1; // RL2
		end
	end
endmodule

`default_nettype wire

// ### hw/cadr_top.sv
// configuration address decode router: address port, data window and routing of
// configuration transactions to internal devices, the express port or the hub link
// assumes the processor holds a request until acknowledged and each far side answers
// every request it receives with one acknowledge pulse
//
// Summary of operation
// RL1: bus zero, foreign device: hub type 0
// RL2: nonzero bus outside bridge range: hub type 1
// RL3: bus equals secondary: express type 0
// RL4: bus above secondary, within subordinate: express type 1
// RL5: bus field to header byte 8, hub A[23:16]
// RL6: bus zero devices 0,1,2 are internal; device 2 only while GFX_PRESENT is high
// RL7: device field to byte 6 [7:3], A[15:11]
// RL8: internal device, function above 1: ignored
// RL9: function field to byte 6 [2:0], A[10:8]
// RL10: register field selects doubleword, bits 7:2
// RL11: enable set: data window makes config transaction
// RL12: data window 32-bit read/write, resets to zero
// RL13: address bit 31 enables config, resets clear
// RL14: address port dword only; partial passes to hub
// RL15: express type 0 to nonzero device aborts
// RL16: enable clear: data window is plain i/o
`timescale 1ns/100ps
`default_nettype none
`include "cadr_map.svh"

module cadr_top (
	input  wire logic        CLOCK,
	input  wire logic        RST,
	input  wire logic        IO_REQ,
	input  wire logic        IO_WR,
	input  wire logic [15:0] IO_ADDR,
	input  wire logic [3:0]  IO_BE,
	input  wire logic [31:0] IO_WDATA,
	output logic             IO_ACK,
	output logic      [31:0] IO_RDATA,
	input  wire logic [7:0]  SEC_BUS,
	input  wire logic [7:0]  SUB_BUS,
	input  wire logic        GFX_PRESENT,
	output logic             CFG_ENABLE,
	output logic             OUT_WR,
	output logic      [3:0]  OUT_BE,
	output logic      [31:0] OUT_WDATA,
	output logic             INT_REQ,
	output logic      [4:0]  INT_DEV,
	output logic      [2:0]  INT_FUNC,
	output logic      [5:0]  INT_REG,
	input  wire logic        INT_ACK,
	input  wire logic [31:0] INT_RDATA,
	output logic             PEX_REQ,
	output logic             PEX_TYPE1,
	output logic      [7:0]  PEX_HDR_B6,
	output logic      [7:0]  PEX_HDR_B7,
	output logic      [7:0]  PEX_HDR_B8,
	input  wire logic        PEX_ACK,
	input  wire logic [31:0] PEX_RDATA,
	output logic             HUB_REQ,
	output logic             HUB_CFG,
	output logic             HUB_TYPE1,
	output logic      [31:0] HUB_ADDR,
	input  wire logic        HUB_ACK,
	input  wire logic [31:0] HUB_RDATA
);
	cadr_pkg::cadr_state_e  state_r, state_nxt;
	cadr_pkg::cadr_target_e tgt_r, tgt_nxt;
	logic [31:0] addr_port_r, addr_port_nxt;
	logic [31:0] data_window_r, data_window_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic        cfg_op_r, cfg_op_nxt;
	logic        out_wr_r, out_wr_nxt;
	logic [3:0]  out_be_r, out_be_nxt;
	logic [31:0] out_wdata_r, out_wdata_nxt;
	logic [4:0]  int_dev_r, int_dev_nxt;
	logic [2:0]  int_func_r, int_func_nxt;
	logic [5:0]  int_reg_r, int_reg_nxt;
	logic        pex_type1_r, pex_type1_nxt;
	logic [7:0]  pex_b6_r, pex_b6_nxt;
	logic [7:0]  pex_b7_r, pex_b7_nxt;
	logic [7:0]  pex_b8_r, pex_b8_nxt;
	logic        hub_cfg_r, hub_cfg_nxt;
	logic        hub_type1_r, hub_type1_nxt;
	logic [31:0] hub_addr_r, hub_addr_nxt;
	logic [31:0] win_merge;
	logic        cfg_space_enable;
	logic        at_addr_port;
	logic        at_data_port;
	logic        full_dw;
	logic        sel_ack;
	logic [31:0] sel_rdata;

	cadr_route_if rif ();

	// ********************************************************************
	// address decode
	// ********************************************************************
	assign rif.addr        = addr_port_r;
	assign rif.sec_bus     = SEC_BUS;
	assign rif.sub_bus     = SUB_BUS;
	assign rif.gfx_present = GFX_PRESENT;

	cadr_decode u_decode (
		.rif (rif)
	);

	assign cfg_space_enable = addr_port_r[`CADR_EN_BIT]; // RL13
	assign at_addr_port     = (IO_ADDR == `CADR_ADDR_PORT);
	assign at_data_port     = (IO_ADDR == `CADR_DATA_PORT);
	assign full_dw          = (IO_BE == `CADR_BE_FULL);

	// ********************************************************************
	// byte-lane merge into the data window
	// ********************************************************************
	// partial writes keep the untouched lanes of the previous window value
	for (genvar b = 0; b < 4; b++) begin : g_lane
		assign win_merge[8*b +: 8] = IO_BE[b] ? IO_WDATA[8*b +: 8] : data_window_r[8*b +: 8];
	end

	// ********************************************************************
	// answer select
	// ********************************************************************
	always_comb begin
		sel_ack   = 1'b0;
		sel_rdata = HUB_RDATA;
		unique case (tgt_r)
			cadr_pkg::TG_INT: begin
				sel_ack   = INT_ACK;
				sel_rdata = INT_RDATA;
			end
			cadr_pkg::TG_PEX: begin
				sel_ack   = PEX_ACK;
				sel_rdata = PEX_RDATA;
			end
			cadr_pkg::TG_HUB: begin
				sel_ack   = HUB_ACK;
				sel_rdata = HUB_RDATA;
			end
			default: begin
				sel_ack   = 1'b0;
				sel_rdata = HUB_RDATA;
			end
		endcase
	end

	// ********************************************************************
	// control and register next values
	// ********************************************************************
	always_comb begin
		state_nxt       = state_r;
		tgt_nxt         = tgt_r;
		addr_port_nxt   = addr_port_r;
		data_window_nxt = data_window_r;
		rdata_nxt       = rdata_r;
		cfg_op_nxt      = cfg_op_r;
		out_wr_nxt      = out_wr_r;
		out_be_nxt      = out_be_r;
		out_wdata_nxt   = out_wdata_r;
		int_dev_nxt     = int_dev_r;
		int_func_nxt    = int_func_r;
		int_reg_nxt     = int_reg_r;
		pex_type1_nxt   = pex_type1_r;
		pex_b6_nxt      = pex_b6_r;
		pex_b7_nxt      = pex_b7_r;
		pex_b8_nxt      = pex_b8_r;
		hub_cfg_nxt     = hub_cfg_r;
		hub_type1_nxt   = hub_type1_r;
		hub_addr_nxt    = hub_addr_r;
		unique case (state_r)
			cadr_pkg::ST_IDLE: begin
				if (IO_REQ) begin
					out_wr_nxt    = IO_WR;
					out_be_nxt    = IO_BE;
					out_wdata_nxt = IO_WDATA;
					cfg_op_nxt    = 1'b0;
					if (at_addr_port && full_dw) begin // RL14
						// reserved bits 30:24 and 1:0 never store, so they read zero
						if (IO_WR)
							addr_port_nxt = IO_WDATA & `CADR_ADDR_WMASK; // RL13
						rdata_nxt = addr_port_r;
						state_nxt = cadr_pkg::ST_DONE;
					end else if (at_data_port && cfg_space_enable) begin // RL11
						cfg_op_nxt = 1'b1;
						if (IO_WR)
							data_window_nxt = win_merge; // RL12
						int_dev_nxt   = rif.dev;
						int_func_nxt  = rif.func;
						int_reg_nxt   = rif.regno;
						pex_b6_nxt    = rif.pex_b6;
						pex_b7_nxt    = rif.pex_b7;
						pex_b8_nxt    = rif.pex_b8;
						hub_addr_nxt  = rif.hub_addr;
						hub_cfg_nxt   = 1'b1;
						pex_type1_nxt = (rif.route == cadr_pkg::RT_PEX1); // RL4
						hub_type1_nxt = (rif.route == cadr_pkg::RT_HUB1); // RL2
						state_nxt     = cadr_pkg::ST_WAIT;
						unique case (rif.route)
							cadr_pkg::RT_INT:  tgt_nxt = cadr_pkg::TG_INT; // RL6
							cadr_pkg::RT_PEX0: tgt_nxt = cadr_pkg::TG_PEX; // RL3
							cadr_pkg::RT_PEX1: tgt_nxt = cadr_pkg::TG_PEX; // RL4
							cadr_pkg::RT_HUB0: tgt_nxt = cadr_pkg::TG_HUB; // RL1
							cadr_pkg::RT_HUB1: tgt_nxt = cadr_pkg::TG_HUB; // RL2
							cadr_pkg::RT_ABORT: begin
								// nobody claims it: reads float high, writes vanish
								rdata_nxt = `CADR_ABORT_DATA; // RL8 RL15
								state_nxt = cadr_pkg::ST_DONE;
							end
							default: state_nxt = cadr_pkg::ST_IDLE;
						endcase
					end else begin
						// partial address-port hits, a disabled window and all other
						// ports go out unchanged as plain i/o on the hub
						hub_cfg_nxt   = 1'b0; // RL14 RL16
						hub_type1_nxt = 1'b0;
						hub_addr_nxt  = {16'h0000, IO_ADDR};
						tgt_nxt       = cadr_pkg::TG_HUB;
						state_nxt     = cadr_pkg::ST_WAIT;
					end
				end
			end
			cadr_pkg::ST_WAIT: begin
				if (sel_ack) begin
					rdata_nxt = sel_rdata;
					// a configuration read leaves its result in the window
					if (cfg_op_r && !out_wr_r)
						data_window_nxt = sel_rdata; // RL12
					state_nxt = cadr_pkg::ST_DONE;
				end
			end
			cadr_pkg::ST_DONE: state_nxt = cadr_pkg::ST_IDLE;
			default:           state_nxt = cadr_pkg::ST_IDLE;
		endcase
	end

	// ********************************************************************
	// registers
	// ********************************************************************
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			state_r       <= cadr_pkg::ST_IDLE;
			tgt_r         <= cadr_pkg::TG_HUB;
			addr_port_r   <= `CADR_ADDR_RST; // RL13
			data_window_r <= `CADR_DATA_RST; // RL12
			rdata_r       <= 32'h0000_0000;
			cfg_op_r      <= 1'b0;
			out_wr_r      <= 1'b0;
			out_be_r      <= 4'h0;
			out_wdata_r   <= 32'h0000_0000;
			int_dev_r     <= 5'h00;
			int_func_r    <= 3'h0;
			int_reg_r     <= 6'h00;
			pex_type1_r   <= 1'b0;
			pex_b6_r      <= 8'h00;
			pex_b7_r      <= 8'h00;
			pex_b8_r      <= 8'h00;
			hub_cfg_r     <= 1'b0;
			hub_type1_r   <= 1'b0;
			hub_addr_r    <= 32'h0000_0000;
		end else begin
			state_r       <= state_nxt;
			tgt_r         <= tgt_nxt;
			addr_port_r   <= addr_port_nxt;
			data_window_r <= data_window_nxt;
			rdata_r       <= rdata_nxt;
			cfg_op_r      <= cfg_op_nxt;
			out_wr_r      <= out_wr_nxt;
			out_be_r      <= out_be_nxt;
			out_wdata_r   <= out_wdata_nxt;
			int_dev_r     <= int_dev_nxt;
			int_func_r    <= int_func_nxt;
			int_reg_r     <= int_reg_nxt;
			pex_type1_r   <= pex_type1_nxt;
			pex_b6_r      <= pex_b6_nxt;
			pex_b7_r      <= pex_b7_nxt;
			pex_b8_r      <= pex_b8_nxt;
			hub_cfg_r     <= hub_cfg_nxt;
			hub_type1_r   <= hub_type1_nxt;
			hub_addr_r    <= hub_addr_nxt;
		end
	end

	// ********************************************************************
	// outputs
	// ********************************************************************
	// requests are levels held through the wait state only
	assign IO_ACK     = (state_r == cadr_pkg::ST_DONE);
	assign IO_RDATA   = rdata_r;
	assign CFG_ENABLE = cfg_space_enable;
	assign OUT_WR     = out_wr_r;
	assign OUT_BE     = out_be_r;
	assign OUT_WDATA  = out_wdata_r;
	assign INT_REQ    = (state_r == cadr_pkg::ST_WAIT) && (tgt_r == cadr_pkg::TG_INT);
	assign INT_DEV    = int_dev_r;
	assign INT_FUNC   = int_func_r;
	assign INT_REG    = int_reg_r;
	assign PEX_REQ    = (state_r == cadr_pkg::ST_WAIT) && (tgt_r == cadr_pkg::TG_PEX);
	assign PEX_TYPE1  = pex_type1_r;
	assign PEX_HDR_B6 = pex_b6_r;
	assign PEX_HDR_B7 = pex_b7_r;
	assign PEX_HDR_B8 = pex_b8_r;
	assign HUB_REQ    = (state_r == cadr_pkg::ST_WAIT) && (tgt_r == cadr_pkg::TG_HUB);
	assign HUB_CFG    = hub_cfg_r;
	assign HUB_TYPE1  = hub_type1_r;
	assign HUB_ADDR   = hub_addr_r;
endmodule

`default_nettype wire

// ### bench/cadr_props.sv
// port checker for the configuration address decode router
// assumes a bind to cadr_top and a single clock domain
`timescale 1ns/100ps
`default_nettype none

module cadr_props (
	input wire logic        CLOCK,
	input wire logic        RST,
	input wire logic        IO_ACK,
	input wire logic [7:0]  SEC_BUS,
	input wire logic [7:0]  SUB_BUS,
	input wire logic        CFG_ENABLE,
	input wire logic        INT_REQ,
	input wire logic [2:0]  INT_FUNC,
	input wire logic        INT_ACK,
	input wire logic        PEX_REQ,
	input wire logic        PEX_TYPE1,
	input wire logic [7:0]  PEX_HDR_B6,
	input wire logic [7:0]  PEX_HDR_B8,
	input wire logic        PEX_ACK,
	input wire logic        HUB_REQ,
	input wire logic        HUB_CFG,
	input wire logic        HUB_TYPE1,
	input wire logic [31:0] HUB_ADDR,
	input wire logic        HUB_ACK
);
	// ************************************************************
	// assertions
	// ************************************************************
	// all checks share the one clock; reset silences them
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (RST);

	a_ack_pulse: assert property (IO_ACK |=> !IO_ACK)
		else $error("io answer longer than one cycle");
	a_far_answer: assert property ((INT_REQ && INT_ACK) || (PEX_REQ && PEX_ACK)
		|| (HUB_REQ && HUB_ACK) |=> IO_ACK && !(INT_REQ || PEX_REQ || HUB_REQ))
		else $error("far answer not passed back");
	a_hub_type0: assert property (HUB_REQ && HUB_CFG && !HUB_TYPE1 |-> HUB_ADDR[31:16] == 16'h0000)
		else $error("hub type 0 carries a bus number");
	a_hub_type1: assert property (HUB_REQ && HUB_CFG && HUB_TYPE1 |-> HUB_ADDR[23:16] != 8'h00
		&& (HUB_ADDR[23:16] < SEC_BUS || HUB_ADDR[23:16] > SUB_BUS)) else $error("hub type 1 bus in range");
	a_pex_type0: assert property (PEX_REQ && !PEX_TYPE1 |-> PEX_HDR_B8 == SEC_BUS
		&& PEX_HDR_B6[7:3] == 5'h00) else $error("express type 0 to wrong bus or device");
	a_pex_type1: assert property (PEX_REQ && PEX_TYPE1 |-> PEX_HDR_B8 > SEC_BUS
		&& PEX_HDR_B8 <= SUB_BUS) else $error("express type 1 bus outside range");
	a_int_func: assert property (INT_REQ |-> INT_FUNC <= 3'h1)
		else $error("internal request with high function");
	a_cfg_gate: assert property (INT_REQ || PEX_REQ || (HUB_REQ && HUB_CFG) |-> CFG_ENABLE)
		else $error("config cycle while disabled");
	a_pex_hold: assert property (PEX_REQ && !PEX_ACK |=> PEX_REQ && $stable(PEX_HDR_B8))
		else $error("express request dropped or changed early");

	// main paths seen at least once
	c_int: cover property (INT_REQ && INT_ACK);
	c_pex1: cover property (PEX_REQ && PEX_TYPE1);
	c_hub1: cover property (HUB_REQ && HUB_CFG && HUB_TYPE1);
endmodule

`default_nettype wire

// ### bench/cadr_host_model.sv
// processor side model: issues one i/o access at a time
// assumes requests are acknowledged by a one cycle pulse on io_ack
`timescale 1ns/100ps
`default_nettype none

module cadr_host_model (
	input wire logic         clock,
	input wire logic         io_ack,
	input wire logic  [31:0] io_rdata,
	output logic             io_req,
	output logic             io_wr,
	output logic      [15:0] io_addr,
	output logic      [3:0]  io_be,
	output logic      [31:0] io_wdata
);
	// ************************************************************
	// access task
	// ************************************************************
	initial begin
		io_req = 1'b0;
		io_wr = 1'b0;
		io_addr = 16'h0000;
		io_be = 4'h0;
		io_wdata = 32'h0000_0000;
	end

	// holds the request until the ack edge; released lines show inverted junk
	task automatic access(input logic wr, input logic [15:0] a, input logic [3:0] be,
		input logic [31:0] wd, output logic [31:0] rd);
		int n;
		@(posedge clock);
		io_req <= 1'b1;
		io_wr <= wr;
		io_addr <= a;
		io_be <= be;
		io_wdata <= wd;
		n = 0;
		do begin
			@(posedge clock);
			n++;
		end while (io_ack !== 1'b1 && n < 100);
		rd = (n < 100) ? io_rdata : 32'hxxxx_xxxx; // a hang reads as unknown
		io_req <= 1'b0;
		io_wr <= ~wr;
		io_addr <= ~a;
		io_be <= ~be;
		io_wdata <= ~wd;
	endtask
endmodule

`default_nettype wire

// ### bench/testbench.sv
// self-checking bench for the configuration address decode router
// assumes cadr_top, the host model and the port checker are compiled first
`timescale 1ns/100ps
`default_nettype none

module testbench;
	// ************************************************************
	// signals and far side responder
	// ************************************************************
	localparam logic [31:0] D_INT = 32'h1111_2222;
	localparam logic [31:0] D_PEX = 32'h3333_4444;
	localparam logic [31:0] D_HUB = 32'h5555_6666;
	logic clock = 1'b0, rst = 1'b1, gfx = 1'b1;
	logic [7:0] sec_bus = 8'h05, sub_bus = 8'h08;
	logic io_req, io_wr, io_ack, cfg_en, out_wr, int_req, pex_req, pex_t1, hub_req, hub_cfg, hub_t1;
	logic [15:0] io_addr;
	logic [3:0] io_be, out_be;
	logic [31:0] io_wdata, io_rdata, out_wdata, hub_addr;
	logic [4:0] int_dev;
	logic [2:0] int_func;
	logic [5:0] int_reg;
	logic [7:0] b6, b7, b8;
	logic int_ack = 1'b0, pex_ack = 1'b0, hub_ack = 1'b0;
	logic [31:0] int_rd = 32'h0000_0000, pex_rd = 32'h0000_0000, hub_rd = 32'h0000_0000;
	logic [2:0] s_tgt = 3'h0;
	logic [13:0] s_int;
	logic [24:0] s_pex;
	logic [33:0] s_hub;
	logic [36:0] s_out;
	int cnt = 0, lat = 0, fail_count = 0, n_tests = 0;

	always #10 clock = ~clock;

	cadr_top dut (.CLOCK(clock), .RST(rst), .IO_REQ(io_req), .IO_WR(io_wr), .IO_ADDR(io_addr),
		.IO_BE(io_be), .IO_WDATA(io_wdata), .IO_ACK(io_ack), .IO_RDATA(io_rdata), .SEC_BUS(sec_bus),
		.SUB_BUS(sub_bus), .GFX_PRESENT(gfx), .CFG_ENABLE(cfg_en), .OUT_WR(out_wr), .OUT_BE(out_be),
		.OUT_WDATA(out_wdata), .INT_REQ(int_req), .INT_DEV(int_dev), .INT_FUNC(int_func),
		.INT_REG(int_reg), .INT_ACK(int_ack), .INT_RDATA(int_rd), .PEX_REQ(pex_req),
		.PEX_TYPE1(pex_t1), .PEX_HDR_B6(b6), .PEX_HDR_B7(b7), .PEX_HDR_B8(b8), .PEX_ACK(pex_ack),
		.PEX_RDATA(pex_rd), .HUB_REQ(hub_req), .HUB_CFG(hub_cfg), .HUB_TYPE1(hub_t1),
		.HUB_ADDR(hub_addr), .HUB_ACK(hub_ack), .HUB_RDATA(hub_rd));

	cadr_host_model host (.clock(clock), .io_ack(io_ack), .io_rdata(io_rdata), .io_req(io_req),
		.io_wr(io_wr), .io_addr(io_addr), .io_be(io_be), .io_wdata(io_wdata));

	// answers after lat idle cycles and records what the request carried
	always @(posedge clock) begin
		int_ack <= 1'b0;
		pex_ack <= 1'b0;
		hub_ack <= 1'b0;
		int_rd <= ~D_INT;
		pex_rd <= ~D_PEX;
		hub_rd <= ~D_HUB;
		if ((int_req || pex_req || hub_req) && !(int_ack || pex_ack || hub_ack)) begin
			if (cnt == lat) begin
				cnt <= 0;
				int_ack <= int_req;
				pex_ack <= pex_req;
				hub_ack <= hub_req;
				int_rd <= D_INT;
				pex_rd <= D_PEX;
				hub_rd <= D_HUB;
				s_tgt <= {int_req, pex_req, hub_req};
				s_int <= {int_dev, int_func, int_reg};
				s_pex <= {pex_t1, b6, b7, b8};
				s_hub <= {hub_cfg, hub_t1, hub_addr};
				s_out <= {out_wr, out_be, out_wdata};
			end else begin
				cnt <= cnt + 1;
			end
		end
	end

	// ************************************************************
	// shared tasks
	// ************************************************************
	task automatic chk(input string name, input logic [63:0] seen, input logic [63:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic summarize;
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	function automatic logic [31:0] mk(input logic [7:0] b, input logic [4:0] d,
		input logic [2:0] f, input logic [5:0] r);
		return {1'b1, 7'h00, b, d, f, r, 2'b00};
	endfunction

	// kind: 0 internal, 1 express, 2 hub, 3 abort
	task automatic route(input logic [31:0] a, input logic [1:0] kind, input logic t1);
		logic [31:0] rd;
		logic [31:0] exp;
		host.access(1'b1, 16'h0CF8, 4'hF, a, rd);
		s_tgt = 3'h0;
		host.access(1'b0, 16'h0CFC, 4'hF, 32'h0000_0000, rd);
		exp = 32'hFFFF_FFFF;
		if (kind == 2'h0) begin
			exp = D_INT;
			chk("internal fields", s_int, {a[15:8], a[7:2]});
		end else if (kind == 2'h1) begin
			exp = D_PEX;
			chk("express header", s_pex, {t1, a[15:8], a[7:2], 2'b00, a[23:16]});
		end else if (kind == 2'h2) begin
			exp = D_HUB;
			chk("hub address", s_hub, {2'b10 | t1, 8'h00, t1 ? a[23:16] : 8'h00, a[15:2], 2'b00});
		end
		chk("target", s_tgt, (kind == 2'h3) ? 3'h0 : 3'h4 >> kind);
		chk("read data", rd, exp);
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	// out of reset the port is disabled, so data window and partial port accesses go out as plain i/o
	task automatic t_plain;
		logic [31:0] rd;
		chk("enable after reset", cfg_en, 1'b0);
		host.access(1'b0, 16'h0CFC, 4'hF, 32'h0000_0000, rd);
		chk("disabled window", {s_hub[33], s_hub[31:0]}, {1'b0, 32'h0000_0CFC});
		chk("disabled read", rd, D_HUB);
		host.access(1'b1, 16'h0CF8, 4'h3, 32'hFFFF_FFFF, rd);
		chk("partial port", {s_hub[33], s_hub[31:0]}, {1'b0, 32'h0000_0CF8});
		host.access(1'b0, 16'h0CF8, 4'hF, 32'h0000_0000, rd);
		chk("port reset value", rd, 32'h0000_0000);
		host.access(1'b1, 16'h0CF8, 4'hF, 32'hFFFF_FFFF, rd);
		chk("enable set", cfg_en, 1'b1);
		host.access(1'b0, 16'h0CF8, 4'hF, 32'h0000_0000, rd);
		chk("port readback", rd, 32'h80FF_FFFC);
	endtask

	// every destination, at the edges of the bridge range, prompt and slow answers
	task automatic t_routes;
		route(mk(8'h00, 5'h03, 3'h2, 6'h05), 2'h2, 1'b0);
		route(mk(8'h09, 5'h04, 3'h1, 6'h03), 2'h2, 1'b1);
		route(mk(8'h04, 5'h00, 3'h0, 6'h01), 2'h2, 1'b1);
		route(mk(8'h05, 5'h00, 3'h7, 6'h3F), 2'h1, 1'b0);
		lat = 3;
		route(mk(8'h08, 5'h1F, 3'h6, 6'h02), 2'h1, 1'b1);
		route(mk(8'h06, 5'h00, 3'h0, 6'h00), 2'h1, 1'b1);
		route(mk(8'h05, 5'h01, 3'h0, 6'h00), 2'h3, 1'b0);
		for (int d = 0; d < 3; d++)
			route(mk(8'h00, 5'(d), 3'h1, 6'(d + 4)), 2'h0, 1'b0);
		route(mk(8'h00, 5'h01, 3'h2, 6'h00), 2'h3, 1'b0);
		gfx <= 1'b0;
		route(mk(8'h00, 5'h02, 3'h0, 6'h09), 2'h2, 1'b0);
	endtask

	// a config write carries its lanes and data out to the far side
	task automatic t_write;
		logic [31:0] rd;
		host.access(1'b1, 16'h0CF8, 4'hF, mk(8'h07, 5'h00, 3'h0, 6'h10), rd);
		host.access(1'b1, 16'h0CFC, 4'h3, 32'h1234_5678, rd);
		chk("write out", s_out, {1'b1, 4'h3, 32'h1234_5678});
		chk("write target", s_tgt, 3'h2);
	endtask

	// a reset in mid-run must drop the enable and clear the address port again
	task automatic t_reset;
		logic [31:0] rd;
		rst <= 1'b1;
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		host.access(1'b0, 16'h0CF8, 4'hF, 32'h0000_0000, rd);
		chk("enable after mid reset", cfg_en, 1'b0);
		chk("port after mid reset", rd, 32'h0000_0000);
	endtask

	initial begin
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		t_plain();
		t_routes();
		t_write();
		t_reset();
		summarize();
	end

	// cuts a hang short; the run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clock);
		fail_count++;
		summarize();
	end
endmodule

bind cadr_top cadr_props u_props (.CLOCK(CLOCK), .RST(RST), .IO_ACK(IO_ACK), .SEC_BUS(SEC_BUS),
	.SUB_BUS(SUB_BUS), .CFG_ENABLE(CFG_ENABLE), .INT_REQ(INT_REQ), .INT_FUNC(INT_FUNC),
	.INT_ACK(INT_ACK), .PEX_REQ(PEX_REQ), .PEX_TYPE1(PEX_TYPE1), .PEX_HDR_B6(PEX_HDR_B6),
	.PEX_HDR_B8(PEX_HDR_B8), .PEX_ACK(PEX_ACK), .HUB_REQ(HUB_REQ), .HUB_CFG(HUB_CFG),
	.HUB_TYPE1(HUB_TYPE1), .HUB_ADDR(HUB_ADDR), .HUB_ACK(HUB_ACK));

`default_nettype wire
